/* File: rtl/emx_pkg.sv */
/*
 * emx_pkg: constants, register word addresses, carriers and shared
 * decode functions for the extended analog channel multiplexer.
 * Assumes 16-bit register words; 32-bit values span two words, high first.
 */
package emx_pkg;
    // ==================================================================
    // channel plan
    localparam int NUM_BUILTIN = 14;
    localparam int EXT_PER     = 8;
    localparam int EXT_FIRST   = 16;
    localparam int EXT_LAST    = 127;
    localparam int NUM_EXT     = 112;
    localparam int MAP_BASE_CH = 48;
    localparam logic [13:0] FITTED_DEF = 14'h3ff0;

    // ==================================================================
    // register word addresses, per-channel bases printed at channel 48
    localparam logic [15:0] VOLT_BASE  = 16'h0060;
    localparam logic [15:0] STRM_RES   = 16'h0faa;
    localparam logic [15:0] NEG_BASE   = 16'ha058;
    localparam logic [15:0] RES_BASE   = 16'ha24c;
    localparam logic [15:0] ALL_NEG    = 16'hab7e;
    localparam logic [15:0] ALL_RES    = 16'hab7f;
    localparam logic [15:0] STRM_RES_LO = STRM_RES + 16'h0001;
    localparam logic [15:0] VOLT_CH0 = VOLT_BASE - 16'(2 * MAP_BASE_CH);
    localparam logic [15:0] NEG_CH0  = NEG_BASE - 16'(MAP_BASE_CH);
    localparam logic [15:0] RES_CH0  = RES_BASE - 16'(MAP_BASE_CH);

    // ==================================================================
    // values and resets
    localparam logic [15:0] SE_NEG   = 16'h00c7;
    localparam logic [15:0] DIFF_ALL = 16'h0001;
    localparam logic [15:0] MIXED    = 16'hffff;
    localparam logic [15:0] RES_RST  = 16'h0000;
    localparam logic [31:0] STRM_RST = 32'h0000_0000;

    // ==================================================================
    // timing: mux settle before each conversion
    localparam int CLK_NS     = 4;
    localparam int SETTLE_NS  = 40;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

    // ==================================================================
    // carriers
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } emx_req_t;

    typedef struct packed {
        logic        err;
        logic [15:0] rdata;
    } emx_rsp_t;

    typedef struct packed {
        logic [3:0]  pos;
        logic [3:0]  neg;
        logic        diff;
        logic [15:0] res;
    } emx_conv_t;

    // ==================================================================
    // decode functions
    function automatic logic pos_ok(input logic [6:0] ch);
        return (ch >= 7'(EXT_FIRST)) && !ch[3];
    endfunction

    function automatic logic pair_ok(input logic [6:0] ch,
                                     input logic [15:0] neg);
        if (ch < 7'(EXT_FIRST))
            return !ch[0] && (neg == 16'(ch) + 16'h0001);
        return pos_ok(ch) && (neg == 16'(ch) + 16'(EXT_PER));
    endfunction
endpackage

/* File: rtl/emx_cfg_store.sv */
/*
 * emx_cfg_store: per-channel negative select and resolution index for
 * extended channels 16..127, with the global write and consistency read.
 * Assumes the caller validates written values and the channel index.
 */
`timescale 1ns/100ps
module emx_cfg_store #(
    parameter int NUM_CH = emx_pkg::NUM_EXT
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [6:0]  idx,
    input  wire logic        neg_we,
    input  wire logic        res_we,
    input  wire logic        all_neg_we,
    input  wire logic        all_res_we,
    input  wire logic [15:0] wdata,
    output logic      [15:0] neg_rd,
    output logic      [15:0] res_rd,
    output logic      [15:0] all_neg_rd,
    output logic      [15:0] all_res_rd
);
    logic [15:0] neg_r   [NUM_CH];
    logic [15:0] neg_nxt [NUM_CH];
    logic [15:0] res_r   [NUM_CH];
    logic [15:0] res_nxt [NUM_CH];

    function automatic logic [6:0] ch_of(input int i);
        return 7'(i + emx_pkg::EXT_FIRST);
    endfunction

    // ==================================================================
    // next values
    always_comb begin
        logic [6:0] ch;
        ch = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            ch = ch_of(i);
            neg_nxt[i] = neg_r[i];
            res_nxt[i] = res_r[i];
            if (all_neg_we) begin
                if (wdata == emx_pkg::DIFF_ALL && emx_pkg::pos_ok(ch))
                    neg_nxt[i] = 16'(ch) + 16'(emx_pkg::EXT_PER);
                else
                    neg_nxt[i] = emx_pkg::SE_NEG;
            end else if (neg_we && idx == ch) begin
                neg_nxt[i] = wdata;
            end
            if (all_res_we || (res_we && idx == ch))
                res_nxt[i] = wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                neg_r[i] <= emx_pkg::SE_NEG;
                res_r[i] <= emx_pkg::RES_RST;
            end
        end else begin
            neg_r <= neg_nxt;
            res_r <= res_nxt;
        end
    end

    // ==================================================================
    // reads; the global view only claims a mode every channel agrees on
    always_comb begin
        logic [6:0] k;
        logic       se;
        logic       df;
        logic       eq;
        k  = idx - 7'(emx_pkg::EXT_FIRST);
        se = 1'b1;
        df = 1'b1;
        eq = 1'b1;
        neg_rd = neg_r[k];
        res_rd = res_r[k];
        for (int i = 0; i < NUM_CH; i++) begin
            se &= (neg_r[i] == emx_pkg::SE_NEG);
            if (emx_pkg::pos_ok(ch_of(i)))
                df &= (neg_r[i] == 16'(ch_of(i)) + 16'(emx_pkg::EXT_PER));
            else
                df &= (neg_r[i] == emx_pkg::SE_NEG);
            eq &= (res_r[i] == res_r[0]);
        end
        all_neg_rd = se ? emx_pkg::SE_NEG
                   : df ? emx_pkg::DIFF_ALL : emx_pkg::MIXED;
        all_res_rd = eq ? res_r[0] : emx_pkg::MIXED;
    end
endmodule

/* File: rtl/emx_mux_ctrl.sv */
/*
 * emx_mux_ctrl: register port, channel mapping and conversion sequencer
 * for extended analog channels driven through external 8:1 multiplexers.
 * Assumes the conversion engine on the same clock answers conv_start
 * with a conv_done pulse; mux_fitted is an asynchronous strap input.
 */
//
// Function
// - each built-in input fans out to eight channels from 16+8*input
// - up to 112 extended channels from 14 built-in inputs
// - a built-in input behind a fitted mux is no longer readable
// - differential positive only in 16-23, 32-39 ... 112-119
// - extended differential negative is positive plus eight
// - built-in pair: even positive, negative one higher
// - reads of channels 16..127 drive the three mux lines first
// - mux address is (channel-16) mod 8, shared by all fourteen muxes
// - with mux on inputs 4-13, inputs 0-3 stay directly readable
// - voltage read of an extended channel returns a 32-bit float
// - each channel holds a negative select, 199 means single-ended; held for channels 16..127 only, built-in reads are single-ended
// - global negative write: 1 all differential, 199 all single-ended
// - global negative read: 1, 199, or 0xffff when mixed
// - each channel holds a resolution index for its readings; held for channels 16..127 only, built-in reads use 0
// - global resolution write sets all; read common value or 0xffff
// - separate 32-bit stream resolution index
//
`timescale 1ns/100ps
module emx_mux_ctrl #(
    parameter logic [13:0] FITTED_RST = emx_pkg::FITTED_DEF
) (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic               req_valid,
    input  wire emx_pkg::emx_req_t  req,
    output logic                    req_ready,
    output logic                    rsp_valid,
    output emx_pkg::emx_rsp_t       rsp,
    input  wire logic [13:0]        mux_fitted,
    output logic [2:0]              mux_address_lines,
    output logic                    conv_start,
    output emx_pkg::emx_conv_t      conv,
    input  wire logic               conv_done,
    input  wire logic [31:0]        conv_volts,
    output logic [31:0]             stream_resolution
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONV} emx_state_t;

    // ==================================================================
    // strap synchroniser
    logic [13:0] fit_meta_r;
    logic [13:0] fit_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fit_meta_r <= '0;
            fit_r      <= '0;
        end else begin
            fit_meta_r <= mux_fitted;
            fit_r      <= fit_meta_r;
        end
    end

    // a channel is readable only if its path matches the fitted muxes
    function automatic logic chan_ok(input logic [6:0]  ch,
                                     input logic [13:0] fit);
        if (ch < 7'(emx_pkg::NUM_BUILTIN))
            return !fit[ch[3:0]];
        if (ch < 7'(emx_pkg::EXT_FIRST))
            return 1'b0;
        return fit[ch[6:3] - 4'd2];
    endfunction

    // ==================================================================
    // decode of the request
    logic [15:0] voff;
    logic [15:0] noff;
    logic [15:0] roff;
    logic        hit_volt;
    logic        hit_neg;
    logic        hit_res;
    logic [6:0]  vch;
    logic [6:0]  sidx;

    always_comb begin
        voff     = req.addr - emx_pkg::VOLT_CH0;
        noff     = req.addr - emx_pkg::NEG_CH0;
        roff     = req.addr - emx_pkg::RES_CH0;
        hit_volt = (voff[15:8] == 8'h00);
        hit_neg  = (noff[15:7] == 9'h000) && (noff[6:4] != 3'h0);
        hit_res  = (roff[15:7] == 9'h000) && (roff[6:4] != 3'h0);
        vch      = voff[7:1];
        sidx     = hit_volt ? vch : hit_neg ? noff[6:0] : roff[6:0];
    end

    // ==================================================================
    // configuration store
    logic        take;
    logic        neg_we;
    logic        res_we;
    logic        all_neg_we;
    logic        all_res_we;
    logic        neg_bad;
    logic [15:0] neg_rd;
    logic [15:0] res_rd;
    logic [15:0] all_neg_rd;
    logic [15:0] all_res_rd;

    always_comb begin
        take    = req_valid && req_ready;
        neg_bad = (req.wdata != emx_pkg::SE_NEG)
               && !emx_pkg::pair_ok(noff[6:0], req.wdata);
        neg_we  = take && req.wr && hit_neg && !neg_bad;
        res_we  = take && req.wr && hit_res;
        all_neg_we = take && req.wr && req.addr == emx_pkg::ALL_NEG
                  && (req.wdata == emx_pkg::SE_NEG
                      || req.wdata == emx_pkg::DIFF_ALL);
        all_res_we = take && req.wr && req.addr == emx_pkg::ALL_RES;
    end

    emx_cfg_store #(
        .NUM_CH (emx_pkg::NUM_EXT)
    ) u_store (
        .mclk       (mclk),
        .resetn     (resetn),
        .idx        (sidx),
        .neg_we     (neg_we),
        .res_we     (res_we),
        .all_neg_we (all_neg_we),
        .all_res_we (all_res_we),
        .wdata      (req.wdata),
        .neg_rd     (neg_rd),
        .res_rd     (res_rd),
        .all_neg_rd (all_neg_rd),
        .all_res_rd (all_res_rd)
    );

    // ==================================================================
    // sequencer and register answers
    emx_state_t         state_r;
    emx_state_t         state_nxt;
    logic [7:0]         cnt_r;
    logic [7:0]         cnt_nxt;
    logic [2:0]         mux_r;
    logic [2:0]         mux_nxt;
    emx_pkg::emx_conv_t conv_r;
    emx_pkg::emx_conv_t conv_nxt;
    logic               start_r;
    logic               start_nxt;
    logic               rv_r;
    logic               rv_nxt;
    emx_pkg::emx_rsp_t  rsp_r;
    emx_pkg::emx_rsp_t  rsp_nxt;
    logic [15:0]        low_r;
    logic [15:0]        low_nxt;
    logic [31:0]        strm_r;
    logic [31:0]        strm_nxt;
    logic               rdy_r;
    logic               rdy_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        mux_nxt   = mux_r;
        conv_nxt  = conv_r;
        start_nxt = 1'b0;
        rv_nxt    = 1'b0;
        rsp_nxt   = rsp_r;
        low_nxt   = low_r;
        strm_nxt  = strm_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    rv_nxt  = 1'b1;
                    rsp_nxt = '{err: 1'b0, rdata: 16'h0000};
                    if (hit_volt && !req.wr && !voff[0]) begin
                        if (chan_ok(vch, fit_r)) begin
                            rv_nxt = 1'b0;
                            // lines move only here, between conversions
                            if (vch >= 7'(emx_pkg::EXT_FIRST))
                                mux_nxt = vch[2:0];
                            conv_nxt.pos = (vch >= 7'(emx_pkg::EXT_FIRST))
                                ? vch[6:3] - 4'd2 : vch[3:0];
                            conv_nxt.diff = (vch >= 7'(emx_pkg::EXT_FIRST))
                                && neg_rd != emx_pkg::SE_NEG;
                            conv_nxt.neg = conv_nxt.pos + 4'd1;
                            conv_nxt.res = (vch >= 7'(emx_pkg::EXT_FIRST))
                                ? res_rd : emx_pkg::RES_RST;
                            cnt_nxt   = 8'(emx_pkg::SETTLE_CYC);
                            state_nxt = ST_SETTLE;
                        end else begin
                            rsp_nxt.err = 1'b1;
                        end
                    end else if (hit_volt && !req.wr) begin
                        rsp_nxt.rdata = low_r;
                    end else if (hit_neg) begin
                        rsp_nxt.err   = req.wr && neg_bad;
                        rsp_nxt.rdata = req.wr ? 16'h0000 : neg_rd;
                    end else if (hit_res) begin
                        rsp_nxt.rdata = req.wr ? 16'h0000 : res_rd;
                    end else if (req.addr == emx_pkg::ALL_NEG) begin
                        rsp_nxt.err   = req.wr && !all_neg_we;
                        rsp_nxt.rdata = req.wr ? 16'h0000 : all_neg_rd;
                    end else if (req.addr == emx_pkg::ALL_RES) begin
                        rsp_nxt.rdata = req.wr ? 16'h0000 : all_res_rd;
                    end else if (req.addr == emx_pkg::STRM_RES) begin
                        if (req.wr)
                            strm_nxt[31:16] = req.wdata;
                        rsp_nxt.rdata = req.wr ? 16'h0000 : strm_r[31:16];
                    end else if (req.addr == emx_pkg::STRM_RES_LO) begin
                        if (req.wr)
                            strm_nxt[15:0] = req.wdata;
                        rsp_nxt.rdata = req.wr ? 16'h0000 : strm_r[15:0];
                    end else begin
                        rsp_nxt.err = 1'b1;
                    end
                end
            end
            ST_SETTLE: begin
                cnt_nxt = cnt_r - 8'd1;
                if (cnt_r == 8'd1) begin
                    start_nxt = 1'b1;
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    rv_nxt    = 1'b1;
                    rsp_nxt   = '{err: 1'b0, rdata: conv_volts[31:16]};
                    low_nxt   = conv_volts[15:0];
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        rdy_nxt = (state_nxt == ST_IDLE);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cnt_r   <= 8'h00;
            mux_r   <= 3'h0;
            conv_r  <= '0;
            start_r <= 1'b0;
            rv_r    <= 1'b0;
            rsp_r   <= '0;
            low_r   <= 16'h0000;
            strm_r  <= emx_pkg::STRM_RST;
            rdy_r   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            mux_r   <= mux_nxt;
            conv_r  <= conv_nxt;
            start_r <= start_nxt;
            rv_r    <= rv_nxt;
            rsp_r   <= rsp_nxt;
            low_r   <= low_nxt;
            strm_r  <= strm_nxt;
            rdy_r   <= rdy_nxt;
        end
    end

    assign req_ready         = rdy_r;
    assign rsp_valid         = rv_r;
    assign rsp               = rsp_r;
    assign mux_address_lines = mux_r;
    assign conv_start        = start_r;
    assign conv              = conv_r;
    assign stream_resolution = strm_r;

    // ==================================================================
    // checks
    localparam int A_SET_HI = emx_pkg::SETTLE_CYC + 1;
    logic [6:0] a_ch_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)
            a_ch_r <= 7'h00;
        else if (take && hit_volt && !voff[0])
            a_ch_r <= vch;
    end

    sequence s_ext_read;
        take && hit_volt && !req.wr && !voff[0] && chan_ok(vch, fit_r)
            && vch >= 7'(emx_pkg::EXT_FIRST);
    endsequence

    sequence s_started;
        ##[1:A_SET_HI] conv_start;
    endsequence

    a_mux_before_conv: assert property (@(posedge mclk) disable iff (!resetn)
        s_ext_read |-> s_started)
        else $error("extended read did not start a conversion");
    a_mux_addr_map: assert property (@(posedge mclk) disable iff (!resetn)
        conv_start && a_ch_r >= 7'd16
        |-> mux_address_lines == 3'(a_ch_r - 7'd16))
        else $error("mux address does not match channel");
    a_pos_map: assert property (@(posedge mclk) disable iff (!resetn)
        conv_start && a_ch_r >= 7'd16
        |-> conv.pos == 4'(a_ch_r[6:3] - 4'd2))
        else $error("built-in input does not match channel");
    // lines may only move on the edge that takes a read in idle
    a_mux_stable: assert property (@(posedge mclk) disable iff (!resetn)
        state_r != ST_IDLE |=> $stable(mux_address_lines))
        else $error("mux lines moved during conversion");
    a_diff_pair: assert property (@(posedge mclk) disable iff (!resetn)
        conv_start && conv.diff
        |-> !conv.pos[0] && conv.neg == conv.pos + 4'd1)
        else $error("differential pair not even and odd");
    a_builtin_block: assert property (@(posedge mclk) disable iff (!resetn)
        take && hit_volt && !req.wr && !voff[0] && vch < 7'd14
        && fit_r[vch[3:0]] |=> rsp_valid && rsp.err)
        else $error("multiplexed built-in input was readable");
    a_neg_reject: assert property (@(posedge mclk) disable iff (!resetn)
        take && req.wr && hit_neg && neg_bad
        |=> rsp_valid && rsp.err && req_ready)
        else $error("bad negative select accepted");
    a_gneg_read: assert property (@(posedge mclk) disable iff (!resetn)
        take && !req.wr && req.addr == emx_pkg::ALL_NEG
        |=> rsp.rdata inside {16'h0001, 16'h00c7, 16'hffff})
        else $error("global negative read out of set");
    a_volt_answer: assert property (@(posedge mclk) disable iff (!resetn)
        state_r == ST_CONV && conv_done
        |=> rsp_valid && rsp.rdata == $past(conv_volts[31:16])
        && req_ready)
        else $error("voltage answer wrong");
    a_stream_res: assert property (@(posedge mclk) disable iff (!resetn)
        take && req.wr && req.addr == emx_pkg::STRM_RES
        |=> stream_resolution[31:16] == $past(req.wdata))
        else $error("stream resolution not written");
endmodule

/* File: tb/emx_far_model.sv */
/* emx_far_model: conversion engine plus external 8:1 muxes.
   Assumes one conv_start at a time from the controller. */
`timescale 1ns/100ps
module emx_far_model (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic               conv_start,
    input  wire emx_pkg::emx_conv_t conv,
    input  wire logic [2:0]         mux_address_lines,
    output logic                    conv_done,
    output logic [31:0]             conv_volts,
    output logic                    slip
);
    // ====
    // engine: slower for higher mux codes, result echoes conv and mux
    logic [2:0]         mux_r;
    emx_pkg::emx_conv_t cv_r;
    int                 wait_r;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            conv_done <= 1'b0;
            conv_volts <= 32'h0;
            slip <= 1'b0;
            wait_r <= 0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                mux_r <= mux_address_lines;
                cv_r <= conv;
                wait_r <= 1 + 4 * int'(mux_address_lines);
            end else if (wait_r > 0) begin
                wait_r <= wait_r - 1;
                if (mux_address_lines !== mux_r)
                    slip <= 1'b1;
                if (wait_r == 1) begin
                    conv_done <= 1'b1;
                    conv_volts <= {7'h20, cv_r.pos, 2'b0, mux_r,
                                   cv_r.pos, cv_r.neg, cv_r.diff,
                                   cv_r.res[3:0], mux_r};
                end
            end else
                // result bus not held outside the done cycle
                conv_volts <= ~conv_volts;
        end
    end
endmodule

/* File: tb/tb_extended_analog_channel_mux.sv */
/* tb_extended_analog_channel_mux: self-checking bench for emx_mux_ctrl.
   Assumes emx_far_model stands in for the engine and muxes. */
`timescale 1ns/100ps
module tb_extended_analog_channel_mux;
    logic               mclk;
    logic               resetn;
    logic               req_valid;
    emx_pkg::emx_req_t  req;
    logic               req_ready;
    logic               rsp_valid;
    emx_pkg::emx_rsp_t  rsp;
    emx_pkg::emx_rsp_t  got;
    logic [13:0]        mux_fitted;
    logic [2:0]         mux_address_lines;
    logic               conv_start;
    emx_pkg::emx_conv_t conv;
    logic               conv_done;
    logic [31:0]        conv_volts;
    logic [31:0]        stream_resolution;
    logic               slip;
    logic [31:0]        rnd;
    logic [2:0]         last_mux;
    int                 bad_count;
    int                 total_checks;
    int                 neg_m [128];
    int                 res_m [128];
    int                 gv [3] = '{1, 199, 5};

    emx_mux_ctrl emx_mux_ctrl_inst (.mclk, .resetn, .req_valid, .req,
        .req_ready, .rsp_valid, .rsp, .mux_fitted, .mux_address_lines,
        .conv_start, .conv, .conv_done, .conv_volts, .stream_resolution);
    emx_far_model emx_far_model_inst (.mclk, .resetn, .conv_start,
        .conv, .mux_address_lines, .conv_done, .conv_volts, .slip);

    // ====
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] gneg();
        logic se = 1'b1;
        logic df = 1'b1;
        for (int c = 16; c < 128; c++) begin
            se &= (neg_m[c] == 199);
            df &= (neg_m[c] == ((c % 16 < 8) ? c + 8 : 199));
        end
        return se ? 16'h00c7 : (df ? 16'h0001 : 16'hffff);
    endfunction

    function automatic logic [15:0] gres();
        for (int c = 17; c < 128; c++)
            if (res_m[c] != res_m[16])
                return 16'hffff;
        return 16'(res_m[16]);
    endfunction

    task automatic results;
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    // request held from a falling edge until taken while ready
    task automatic rw(input logic w, input logic [15:0] a,
                      input logic [15:0] d, input logic [16:0] e);
        int k;
        @(negedge mclk);
        req = '{w, a, d};
        req_valid = 1'b1;
        for (k = 0; k < 3000 && req_ready !== 1'b1; k++)
            @(negedge mclk);
        if (k == 3000) begin
            bad_count++;
            $display("BAD %0t never ready", $time);
            results();
        end
        @(negedge mclk);
        req_valid = 1'b0;
        for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++)
            @(negedge mclk);
        if (k == 3000) begin
            bad_count++;
            $display("BAD %0t no answer", $time);
            results();
        end
        got = rsp;
        // write data and refused reads carry no defined rdata
        chk((w || e[16]) ? {got.err, 16'h0} : got, e);
    endtask

    task automatic negw(input int ch, input int v, input logic ok);
        rw(1, emx_pkg::NEG_CH0 + 16'(ch), 16'(v), {!ok, 16'h0});
        if (ok)
            neg_m[ch] = v;
        rw(0, emx_pkg::NEG_CH0 + 16'(ch), 0, {1'b0, 16'(neg_m[ch])});
    endtask

    task automatic volt(input int ch, input logic ok);
        int   p;
        int   r;
        logic d;
        p = (ch >= 16) ? (ch - 16) / 8 : ch;
        r = (ch >= 16) ? res_m[ch] : 0;
        d = (ch >= 16) && (neg_m[ch] != 199);
        if (ok && ch >= 16)
            last_mux = 3'(ch - 16);
        rw(0, emx_pkg::VOLT_CH0 + 16'(2 * ch), 0,
           ok ? {1'b0, 7'h20, 4'(p), 2'b0, last_mux} : 17'h10000);
        if (ok)
            rw(0, emx_pkg::VOLT_CH0 + 16'(2 * ch + 1), 0,
               {1'b0, 4'(p), 4'(p + 1), d, 4'(r), last_mux});
    endtask

    // ====
    // clock and sequence
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        mux_fitted = emx_pkg::FITTED_DEF;
        bad_count = 0;
        total_checks = 0;
        rnd = 32'h861b;
        last_mux = 3'h0;
        foreach (neg_m[c]) begin
            neg_m[c] = 199;
            res_m[c] = 0;
        end
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        rw(0, emx_pkg::NEG_CH0 + 16'd48, 0, 17'h000c7);
        rw(0, emx_pkg::ALL_NEG, 0, {1'b0, gneg()});
        negw(48, 56, 1);
        negw(48, 57, 0);
        negw(56, 64, 0);
        negw(119, 127, 1);
        rw(0, emx_pkg::ALL_NEG, 0, {1'b0, gneg()});
        foreach (gv[i]) begin
            rw(1, emx_pkg::ALL_NEG, 16'(gv[i]),
               {gv[i] == 5, 16'h0});
            for (int c = 16; c < 128 && gv[i] != 5; c++)
                neg_m[c] = (gv[i] == 1 && c % 16 < 8) ? c + 8 : 199;
            rw(0, emx_pkg::ALL_NEG, 0, {1'b0, gneg()});
            rw(0, emx_pkg::NEG_CH0 + 16'd32, 0, 17'(neg_m[32]));
        end
        rnd = lfsr(rnd);
        rw(1, emx_pkg::ALL_RES, 16'(rnd[3:0]), 17'h0);
        foreach (res_m[c])
            res_m[c] = int'(rnd[3:0]);
        rw(0, emx_pkg::ALL_RES, 0, {1'b0, gres()});
        res_m[99] = int'(rnd[3:0] ^ 4'h1);
        rw(1, emx_pkg::RES_CH0 + 16'd99, 16'(res_m[99]), 17'h0);
        rw(0, emx_pkg::RES_CH0 + 16'd99, 0, 17'(res_m[99]));
        rw(0, emx_pkg::ALL_RES, 0, {1'b0, gres()});
        rnd = lfsr(rnd);
        rw(1, emx_pkg::STRM_RES, rnd[31:16], 17'h0);
        rw(1, emx_pkg::STRM_RES_LO, rnd[15:0], 17'h0);
        chk({1'b0, stream_resolution}, {1'b0, rnd});
        rw(0, emx_pkg::STRM_RES, 0, {1'b0, rnd[31:16]});
        volt(48, 1);
        volt(127, 1);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            volt(48 + int'(rnd[15:0]) % 80, 1);
        end
        volt(4, 0);
        volt(16, 0);
        volt(2, 1);
        volt(99, 1);
        negw(48, 56, 1);
        volt(48, 1);
        rw(1, emx_pkg::VOLT_CH0 + 16'd96, 16'h1, 17'h10000);
        rw(0, 16'h7777, 0, 17'h10000);
        mux_fitted = 14'h3ff1;
        repeat (3) @(negedge mclk);
        volt(16, 1);
        volt(0, 0);
        chk({32'h0, slip}, 33'h0);
        results();
    end
endmodule
